//--- logic/sbwa_bank.v
// interrupt bank slice: bank-b result, bank-c source and enable
`include "sbwa_regs.vh"

// Function
// - Bank-b result bit 31 is a read/write normalize helper bit; the GPIO result bits are read-only.
// - The 32-bit bank-c source register has write-one-to-clear defined bits and read-only reserved bits.
// - The 32-bit bank-c enable register has read/write defined bits and read-only reserved bits.
// - Source bits 0 to 2 are set by the requests of bus controllers 0 to 2 and are not wake sources.
// - Source bits 3 to 16 are set by data-line edges on ports 00-07, 10-12 and 20-22, all wake-capable.
// - Source bit 17 is the wake-capable thermal interrupt of port 23.
// - Source bits 18 to 31 are reserved, read-only, non-wake and without interrupt function.
// - Each defined source bit has its enable and result bit at the same position.
// - A source bit stays set until software writes one to it; writing zero leaves it alone.
module sbwa_bank (
  input  wire        CLK,
  input  wire        NRST,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  output reg  [31:0] REG_RDATA,
  input  wire [26:0] GPIO_B_RESULT_IN,
  input  wire        BUS_CTRL_ZERO_IRQ,
  input  wire        BUS_CTRL_ONE_IRQ,
  input  wire        BUS_CTRL_TWO_IRQ,
  input  wire [13:0] SERIAL_DATA_LINE,
  input  wire        PORT23_THERMAL_WAKE,
  output reg         BANK_C_IRQ,
  output reg         BANK_C_WAKE
);
  // register selects, one per mapped offset
  wire        sel_res_b;
  wire        sel_src_c;
  wire        sel_en_c;
  wire        wr_res_b;
  wire        wr_src_c;
  wire        wr_en_c;

  // event side
  wire [13:0] wake_edge;
  wire [31:0] set_vec;
  wire [31:0] clr_req;

  // bank-c state, gathered from the per-bit cells
  wire [31:0] source_q;
  wire [31:0] enable_q;
  wire [31:0] result_c;
  wire [31:0] wake_res_c;

  // per-register read words
  wire [31:0] rd_word_b;
  wire [31:0] rd_word_src;
  wire [31:0] rd_word_en;

  // bank-b normalize helper bit
  reg         normalize_helper_bit_b_q;
  reg         normalize_helper_bit_b_d;

  // read path and output next values
  reg  [31:0] rdata_d;
  reg  [31:0] rdata_next_d;
  reg         irq_d;
  reg         wake_d;

  localparam [31:0] def_mask  = `SBWA_C_DEF_MASK;
  localparam [31:0] wake_mask = `SBWA_C_WAKE_MASK;
  localparam [31:0] rst_word  = `SBWA_RST_WORD;

  sbwa_edge_det u_edge (
    .clk      (CLK),
    .nrst     (NRST),
    .line_in  (SERIAL_DATA_LINE),
    .edge_out (wake_edge)
  );

  // unmapped offsets ignore writes and read zero
  assign sel_res_b = (REG_ADDR == `SBWA_OFS_B_RESULT);
  assign sel_src_c = (REG_ADDR == `SBWA_OFS_C_SOURCE);
  assign sel_en_c  = (REG_ADDR == `SBWA_OFS_C_ENABLE);

  // single-cycle strobes, no wait states
  assign wr_res_b = REG_WR & sel_res_b;
  assign wr_src_c = REG_WR & sel_src_c;
  assign wr_en_c  = REG_WR & sel_en_c;

  assign clr_req = wr_src_c ? REG_WDATA : 32'h0000_0000;

  assign set_vec[2:0] = {BUS_CTRL_TWO_IRQ, BUS_CTRL_ONE_IRQ, BUS_CTRL_ZERO_IRQ};

  assign set_vec[16:3] = wake_edge;

  assign set_vec[17] = PORT23_THERMAL_WAKE;

  assign set_vec[31:18] = 14'h0000;

  genvar b;
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_bit
      if (def_mask[b]) begin : g_def
        reg src_bit_q;
        reg src_bit_d;
        reg en_bit_q;
        reg en_bit_d;

        always @* begin
          src_bit_d = src_bit_q;
          if (clr_req[b]) begin
            src_bit_d = 1'b0;
          end
          // an event in the clearing cycle must not be lost
          if (set_vec[b]) begin
            src_bit_d = 1'b1;
          end
        end

        always @* begin
          en_bit_d = en_bit_q;
          if (wr_en_c) begin
            en_bit_d = REG_WDATA[b];
          end
        end

        always @(posedge CLK or negedge NRST) begin
          if (!NRST) begin
            src_bit_q <= rst_word[b];
            en_bit_q  <= rst_word[b];
          end else begin
            src_bit_q <= src_bit_d;
            en_bit_q  <= en_bit_d;
          end
        end

        assign source_q[b] = src_bit_q;
        assign enable_q[b] = en_bit_q;
      end else begin : g_rsv
        assign source_q[b] = 1'b0;
        assign enable_q[b] = 1'b0;
      end
    end
  endgenerate

  assign result_c   = source_q & enable_q;
  assign wake_res_c = result_c & wake_mask;

  assign rd_word_b   = {normalize_helper_bit_b_q, 4'h0, GPIO_B_RESULT_IN};
  assign rd_word_src = source_q;
  assign rd_word_en  = enable_q;

  always @* begin
    normalize_helper_bit_b_d = normalize_helper_bit_b_q;
    if (wr_res_b) begin
      normalize_helper_bit_b_d = REG_WDATA[`SBWA_NORMALIZE_HELPER_BIT_BIT];
    end
  end

  always @* begin
    case (REG_ADDR)
      `SBWA_OFS_B_RESULT: rdata_d = rd_word_b;
      `SBWA_OFS_C_SOURCE: rdata_d = rd_word_src;
      `SBWA_OFS_C_ENABLE: rdata_d = rd_word_en;
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  // read data held until the next read strobe
  always @* begin
    rdata_next_d = REG_RDATA;
    if (REG_RD) begin
      rdata_next_d = rdata_d;
    end
  end

  // or of results
  // wake only from wake-capable bits, gated by enable
  always @* begin
    irq_d  = |result_c;
    wake_d = |wake_res_c;
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      normalize_helper_bit_b_q <= rst_word[`SBWA_NORMALIZE_HELPER_BIT_BIT];
    end else begin
      normalize_helper_bit_b_q <= normalize_helper_bit_b_d;
    end
  end

  // outputs registered, so the bank interrupt lags its source by one cycle
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA   <= rst_word;
      BANK_C_IRQ  <= 1'b0;
      BANK_C_WAKE <= 1'b0;
    end else begin
      REG_RDATA   <= rdata_next_d;
      BANK_C_IRQ  <= irq_d;
      BANK_C_WAKE <= wake_d;
    end
  end
endmodule // sbwa_bank

//--- logic/sbwa_regs.vh
// register offsets, field layout and reset values of the bank slice
`ifndef SBWA_REGS_VH
`define SBWA_REGS_VH
`define SBWA_OFS_B_RESULT   8'h44
`define SBWA_OFS_C_SOURCE   8'h50
`define SBWA_OFS_C_ENABLE   8'h54
`define SBWA_NORMALIZE_HELPER_BIT_BIT       31
`define SBWA_B_GPIO_MASK    32'h07ff_ffff
`define SBWA_C_DEF_MASK     32'h0003_ffff
`define SBWA_C_CTRL_LSB     0
`define SBWA_C_CTRL_CNT     3
`define SBWA_C_WAKE_LSB     3
`define SBWA_C_WAKE_CNT     14
`define SBWA_C_WAKE_MASK    32'h0003_fff8
`define SBWA_RST_WORD       32'h0000_0000
`endif

//--- logic/sbwa_edge_det.v
// per-line edge detector for the serial data line wake inputs
module sbwa_edge_det (
  input  wire        clk,
  input  wire        nrst,
  input  wire [13:0] line_in,
  output wire [13:0] edge_out
);
  reg  [13:0] prev_q;
  reg         armed_q;

  // first sample after reset only arms, so the reset level is no edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q  <= 14'h0000;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= line_in;
      armed_q <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 14; i = i + 1) begin : g_edge
      assign edge_out[i] = armed_q & (line_in[i] ^ prev_q[i]);
    end
  endgenerate
endmodule // sbwa_edge_det

//--- verification/sbwa_bank_chk.sv
// port assertions for the bank slice
module sbwa_bank_chk(input logic CLK, NRST, REG_WR, REG_RD, BANK_C_IRQ, BANK_C_WAKE,
  input logic [7:0] REG_ADDR, input logic [31:0] REG_RDATA);
timeunit 1ns/1ns;
default clocking @(posedge CLK); endclocking
default disable iff (!NRST);
logic rd_q;
logic [7:0] ad_q;
always @(posedge CLK) {rd_q, ad_q} <= {REG_RD, REG_ADDR};
chk_wake_irq: assert property (BANK_C_WAKE |-> BANK_C_IRQ) else $error("wake alone");
chk_c_rsv: assert property (rd_q && ad_q[7:4] == 4'h5 |-> !REG_RDATA[31:18])
  else $error("reserved set");
chk_irq_drop: assert property ($fell(BANK_C_IRQ) |-> $past(REG_WR, 2)) else $error("irq fell");
chk_normalize_helper_bit_rsv: assert property (rd_q && ad_q == 8'h44 |-> REG_RDATA[30:27] == 4'h0)
  else $error("bank b gap set");
chk_unmapped_zero: assert property (rd_q && !(ad_q inside {8'h44, 8'h50, 8'h54})
  |-> REG_RDATA == 32'h0) else $error("unmapped read");
chk_rdata_hold: assert property (!rd_q |-> $stable(REG_RDATA)) else $error("rdata moved");
endmodule // sbwa_bank_chk
bind sbwa_bank sbwa_bank_chk u_chk(.*);

//--- verification/sbwa_src.sv
// event source model for the bank inputs
module sbwa_src(input logic clk, go, output logic [2:0] ci = 0, output logic [13:0] sd = 0);
timeunit 1ns/1ns;
always @(negedge clk) {ci, sd} <= {{3{go}}, go ? ~sd : sd};
endmodule // sbwa_src

//--- verification/sbwa_bank_test.sv
// self-checking bench for the bank slice
module sbwa_bank_test;
timeunit 1ns/1ns;
logic CLK = 0, NRST = 0, REG_WR = 0, REG_RD = 0, go = 0, BANK_C_IRQ, BANK_C_WAKE;
logic [2:0] ci;
logic [13:0] sd;
logic [7:0] REG_ADDR = 0;
logic [31:0] REG_WDATA = 0, REG_RDATA;
int num_errors = 0, tests_run = 0;
always #10 CLK = ~CLK;
sbwa_src u_src(.clk(CLK), .go, .ci, .sd);
sbwa_bank u_dut(.*, .GPIO_B_RESULT_IN(27'h5a5a5a5), .BUS_CTRL_ZERO_IRQ(ci[0]),
  .BUS_CTRL_ONE_IRQ(ci[1]), .BUS_CTRL_TWO_IRQ(ci[2]), .PORT23_THERMAL_WAKE(ci[0]),
  .SERIAL_DATA_LINE(sd));
task chk(input logic [31:0] g, e);
  tests_run++;
  if (g !== e) begin
    num_errors++;
    $display("ERROR %0t: got %h want %h", $time, g, e);
  end
endtask
task acc(input logic w, logic [7:0] a, logic [31:0] d);
  @(negedge CLK) {REG_WR, REG_RD, REG_ADDR, REG_WDATA} <= {w, !w, a, d};
  @(negedge CLK) {REG_WR, REG_RD} <= 0;
endtask
task rd(input logic [7:0] a, logic [31:0] e);
  acc(0, a, 0);
  chk(REG_RDATA, e);
endtask
task print_verdict;
  $display("checks %0d errors %0d", tests_run, num_errors);
  if (num_errors == 0 && tests_run > 0) $display("All checks passed");
  else $display("Checks failed");
  $finish;
endtask
initial #4000 begin num_errors++; print_verdict; end
initial begin
  repeat (12) @(negedge CLK);
  NRST = 1;
  rd(8'h44, 32'h05a5a5a5); rd(8'h50, 0); rd(8'h54, 0);
  acc(1, 8'h44, '1); rd(8'h44, 32'h85a5a5a5);
  acc(1, 8'h50, '1); rd(8'h50, 0);
  acc(1, 8'h54, '1); rd(8'h54, 32'h3ffff); rd(8'h60, 0);
  @(posedge CLK) go <= 1;
  @(posedge CLK) go <= 0;
  rd(8'h50, 32'h3ffff);
  acc(1, 8'h50, 0); rd(8'h50, 32'h3ffff); chk({BANK_C_IRQ, BANK_C_WAKE}, 3);
  acc(1, 8'h54, 1); chk({BANK_C_IRQ, BANK_C_WAKE}, 3); rd(8'h54, 1);
  chk({BANK_C_IRQ, BANK_C_WAKE}, 2);
  acc(1, 8'h50, 7); rd(8'h50, 32'h3fff8); chk(BANK_C_IRQ, 0);
  $display("bank test done");
  print_verdict;
end
endmodule // sbwa_bank_test
